// [hw/ert_pkg.sv]
// constants and types for the egress redundancy tag and stacking header rewriter
package ert_pkg;
	localparam int          NUM_PORTS        = 4;
	localparam logic [7:0]  ADDR_COMMON      = 8'h00;
	localparam logic [7:0]  ADDR_PORT0       = 8'h04;
	localparam logic [7:0]  ADDR_GROUP0      = 8'h14;
	localparam logic [7:0]  ADDR_GROUP1      = 8'h18;
	localparam logic [7:0]  ADDR_STATUS      = 8'h1C;
	localparam int          COM_AWARE_BIT    = 0;
	localparam int          COM_CNTOFF_BIT   = 1;
	localparam int          COM_UNIT_LSB     = 4;
	localparam int          PRT_INSERT_BIT   = 0;
	localparam int          PRT_GROUP_BIT    = 1;
	localparam int          PRT_PAD_BIT      = 2;
	localparam int          PRT_MIRROR_BIT   = 3;
	localparam int          PRT_MISC_BIT     = 4;
	localparam int          GRP_HOP_LSB      = 0;
	localparam int          GRP_LRN_BIT      = 8;
	localparam int          GRP_XLATE_BIT    = 9;
	localparam int          STS_REFUSE_LSB   = 16;
	localparam logic [4:0]  GRP_HOP_RESET    = 5'h1F;
	localparam logic [6:0]  MIN_LEN_PLAIN    = 7'd64;
	localparam logic [6:0]  MIN_LEN_STACK    = 7'd76;
	localparam logic [2:0]  QOS_TOP          = 3'h7;
	localparam logic [1:0]  POS_ABSENT       = 2'h0;
	localparam logic [1:0]  MAX_TAGS         = 2'h3;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef enum logic [2:0] {
		FWD_LOOKUP, FWD_LOGICAL, FWD_PHYSICAL, FWD_MULTICAST, FWD_GLOBAL_MIRROR, FWD_GCPU
	} ert_fwd_type;

	typedef struct packed {
		logic [1:0]  port;
		logic [1:0]  tag_cnt;       // vlan tags in frame, redundancy tag not counted
		logic [1:0]  redund_pos;    // parsed position of redundancy tag
		logic        ingress_redund_tag_seen;
		logic [1:0]  vlan_pop_cnt;
		logic [1:0]  vlan_push_cnt;
		logic        redund_tag_pop_en;
		logic [1:0]  redund_tag_push_pos;
		ert_fwd_type fwd_mode;
		logic        learn_all;
		logic [2:0]  qos;
		logic        was_tagged;
	} ert_req_type;

	typedef struct packed {
		logic        redund_pop;
		logic        redund_push;
		logic        redund_keep;
		logic        new_sequence;
		logic [1:0]  redund_out_pos;
		logic [15:0] frame_sequence_count;
		logic        push_refused;
		logic        pos_invalid;
		logic [6:0]  min_len;
		logic        stack_header_insert_en;
		logic [5:0]  stack_unit_id;
		logic [4:0]  stack_link_hop_limit;
		logic [2:0]  stack_qos;
		ert_fwd_type fwd_mode;
		logic        mirror_tag;
		logic        misc_field_decode_sel;
		logic        service_count_en;
	} ert_rsp_type;

	typedef struct packed {
		logic stack_header_insert_en;
		logic stack_port_group_sel;
		logic stack_pad_en;
		logic remote_mirror_tag_follow;
		logic misc_field_decode_sel;
	} ert_port_type;

	typedef struct packed {
		logic [4:0] stack_link_hop_limit;
		logic       learn_all_top_prio_en;
		logic       forward_mode_translate_off;
	} ert_group_type;
endpackage

// [hw/ert_rewriter.sv]
// egress rewriter: redundancy tag stack decisions and stacking header fields
`timescale 1ns/10ps
`default_nettype none
module ert_rewriter (
	// clock and reset
	input  wire logic                 MCLK_IN,
	input  wire logic                 SYS_RST_IN,
	// axi4-lite write
	input  wire logic [7:0]           AWADDR_IN,
	input  wire logic                 AWVALID_IN,
	output var  logic                 AWREADY_OUT,
	input  wire logic [31:0]          WDATA_IN,
	input  wire logic [3:0]           WSTRB_IN,
	input  wire logic                 WVALID_IN,
	output var  logic                 WREADY_OUT,
	output var  logic [1:0]           BRESP_OUT,
	output var  logic                 BVALID_OUT,
	input  wire logic                 BREADY_IN,
	// axi4-lite read
	input  wire logic [7:0]           ARADDR_IN,
	input  wire logic                 ARVALID_IN,
	output var  logic                 ARREADY_OUT,
	output var  logic [31:0]          RDATA_OUT,
	output var  logic [1:0]           RRESP_OUT,
	output var  logic                 RVALID_OUT,
	input  wire logic                 RREADY_IN,
	// frame decision request from queue system
	input  wire ert_pkg::ert_req_type FRM_REQ_IN,
	input  wire logic                 FRM_VALID_IN,
	// decision toward egress port
	output var  ert_pkg::ert_rsp_type FRM_RSP_OUT,
	output var  logic                 FRM_VALID_OUT
);
	import ert_pkg::*;

	logic                 aware;
	logic                 count_off;
	logic [5:0]           local_unit_id;
	ert_port_type         port_cfg [NUM_PORTS];
	ert_group_type        grp_cfg [2];
	logic [15:0]          seq_cnt;
	logic [15:0]          refuse_cnt;
	logic [7:0]           aw_addr;
	logic                 aw_held;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;
	logic                 w_held;
	ert_rsp_type          next_rsp;

	// ---------------- register bus ----------------
	wire aw_hs = AWVALID_IN && AWREADY_OUT;
	wire w_hs  = WVALID_IN && WREADY_OUT;
	wire ar_hs = ARVALID_IN && ARREADY_OUT;
	wire do_wr = aw_held && w_held && !BVALID_OUT;

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= ADDR_STATUS;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			AWREADY_OUT <= 1'b0;
			aw_held     <= 1'b0;
			aw_addr     <= 8'h00;
		end else if (aw_hs) begin
			AWREADY_OUT <= 1'b0;
			aw_held     <= 1'b1;
			aw_addr     <= AWADDR_IN;
		end else begin
			if (do_wr) begin
				aw_held <= 1'b0;
			end
			AWREADY_OUT <= !aw_held && !BVALID_OUT;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			WREADY_OUT <= 1'b0;
			w_held     <= 1'b0;
			w_data     <= 32'h0000_0000;
			w_strb     <= 4'h0;
		end else if (w_hs) begin
			WREADY_OUT <= 1'b0;
			w_held     <= 1'b1;
			w_data     <= WDATA_IN;
			w_strb     <= WSTRB_IN;
		end else begin
			if (do_wr) begin
				w_held <= 1'b0;
			end
			WREADY_OUT <= !w_held && !BVALID_OUT;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			BVALID_OUT <= 1'b0;
			BRESP_OUT  <= RESP_OKAY;
		end else if (do_wr) begin
			BVALID_OUT <= 1'b1;
			BRESP_OUT  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (BREADY_IN) begin
			BVALID_OUT <= 1'b0;
		end
	end

	// byte merge over the current word, kept out of the clocked process
	logic [31:0] v;
	always_comb begin
		v = merge(rd_word(aw_addr), w_data, w_strb);
	end

	// configuration writes; status word is read-only
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			aware         <= 1'b0;
			count_off     <= 1'b0;
			local_unit_id <= 6'h00;
			for (int p = 0; p < NUM_PORTS; p++) begin
				port_cfg[p] <= '0;
			end
			for (int g = 0; g < 2; g++) begin
				grp_cfg[g] <= '{stack_link_hop_limit: GRP_HOP_RESET, default: 1'b0};
			end
		end else if (do_wr) begin
			if (aw_addr == ADDR_COMMON) begin
				aware         <= v[COM_AWARE_BIT];
				count_off     <= v[COM_CNTOFF_BIT];
				local_unit_id <= v[COM_UNIT_LSB +: 6];
			end
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (aw_addr == ADDR_PORT0 + 8'(4 * p)) begin
					port_cfg[p] <= '{stack_header_insert_en: v[PRT_INSERT_BIT],
						stack_port_group_sel: v[PRT_GROUP_BIT], stack_pad_en: v[PRT_PAD_BIT],
						remote_mirror_tag_follow: v[PRT_MIRROR_BIT], misc_field_decode_sel: v[PRT_MISC_BIT]};
				end
			end
			for (int g = 0; g < 2; g++) begin
				if (aw_addr == (g == 0 ? ADDR_GROUP0 : ADDR_GROUP1)) begin
					grp_cfg[g] <= '{stack_link_hop_limit: v[GRP_HOP_LSB +: 5],
						learn_all_top_prio_en: v[GRP_LRN_BIT], forward_mode_translate_off: v[GRP_XLATE_BIT]};
				end
			end
		end
	end

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == ADDR_COMMON) begin
			r[COM_AWARE_BIT]      = aware;
			r[COM_CNTOFF_BIT]     = count_off;
			r[COM_UNIT_LSB +: 6]  = local_unit_id;
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (a == ADDR_PORT0 + 8'(4 * p)) begin
				r[PRT_INSERT_BIT] = port_cfg[p].stack_header_insert_en;
				r[PRT_GROUP_BIT]  = port_cfg[p].stack_port_group_sel;
				r[PRT_PAD_BIT]    = port_cfg[p].stack_pad_en;
				r[PRT_MIRROR_BIT] = port_cfg[p].remote_mirror_tag_follow;
				r[PRT_MISC_BIT]   = port_cfg[p].misc_field_decode_sel;
			end
		end
		for (int g = 0; g < 2; g++) begin
			if (a == (g == 0 ? ADDR_GROUP0 : ADDR_GROUP1)) begin
				r[GRP_HOP_LSB +: 5] = grp_cfg[g].stack_link_hop_limit;
				r[GRP_LRN_BIT]      = grp_cfg[g].learn_all_top_prio_en;
				r[GRP_XLATE_BIT]    = grp_cfg[g].forward_mode_translate_off;
			end
		end
		if (a == ADDR_STATUS) begin
			r = {refuse_cnt, seq_cnt};
		end
		return r;
	endfunction

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT  <= 1'b0;
			RDATA_OUT   <= 32'h0000_0000;
			RRESP_OUT   <= RESP_OKAY;
		end else if (ar_hs) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT  <= 1'b1;
			RDATA_OUT   <= rd_word(ARADDR_IN);
			RRESP_OUT   <= mapped(ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (RREADY_IN) begin
				RVALID_OUT <= 1'b0;
			end
			ARREADY_OUT <= !RVALID_OUT;
		end
	end

	// ---------------- frame decision ----------------
	logic [1:0] pos;
	logic       pos_bad;
	logic [1:0] front_cnt;
	logic       can_pop;
	logic       do_pop;
	logic       do_push;
	logic       keep;
	logic       grp;

	always_comb begin
		ert_port_type  pc;
		ert_group_type gc;
		pc = port_cfg[FRM_REQ_IN.port];
		grp = pc.stack_port_group_sel;
		gc = grp_cfg[grp];
		// unaware: redundancy tag is just the frame type, vlan tags ahead still parsed
		pos = aware ? FRM_REQ_IN.redund_pos : POS_ABSENT;
		// tag count limits the legal positions; with a redundancy tag at most two vlan tags
		pos_bad = pos != POS_ABSENT && (pos > FRM_REQ_IN.tag_cnt + 2'h1 || FRM_REQ_IN.tag_cnt == MAX_TAGS);
		if (pos_bad) begin
			pos = POS_ABSENT;
		end
		front_cnt = (pos == POS_ABSENT) ? 2'h0 : pos - 2'h1;
		can_pop   = pos != POS_ABSENT && FRM_REQ_IN.vlan_pop_cnt >= front_cnt;
		do_pop    = FRM_REQ_IN.redund_tag_pop_en && FRM_REQ_IN.ingress_redund_tag_seen && can_pop;
		keep      = pos != POS_ABSENT && !do_pop;
		// pushed tag replaces a pushed vlan slot, so the push total never grows
		do_push   = aware && FRM_REQ_IN.redund_tag_push_pos != POS_ABSENT
			&& !keep && (do_pop || !FRM_REQ_IN.ingress_redund_tag_seen)
			&& FRM_REQ_IN.redund_tag_push_pos <= FRM_REQ_IN.vlan_push_cnt;
		next_rsp = '0;
		next_rsp.redund_pop     = do_pop;
		next_rsp.redund_push    = do_push;
		next_rsp.redund_keep    = keep;
		next_rsp.new_sequence   = do_pop && do_push;
		next_rsp.pos_invalid    = pos_bad;
		next_rsp.push_refused   = FRM_REQ_IN.redund_tag_push_pos != POS_ABSENT && !do_push;
		next_rsp.frame_sequence_count = seq_cnt;
		if (do_push) begin
			next_rsp.redund_out_pos = FRM_REQ_IN.redund_tag_push_pos;
		end else if (keep) begin
			// kept tag sits under remaining front tags, innermost of any pushed tags
			next_rsp.redund_out_pos = front_cnt - FRM_REQ_IN.vlan_pop_cnt + FRM_REQ_IN.vlan_push_cnt + 2'h1;
		end
		next_rsp.stack_header_insert_en = pc.stack_header_insert_en;
		next_rsp.stack_unit_id          = local_unit_id;
		next_rsp.min_len                = pc.stack_pad_en ? MIN_LEN_STACK : MIN_LEN_PLAIN;
		next_rsp.stack_link_hop_limit   = gc.stack_link_hop_limit;
		next_rsp.stack_qos = (FRM_REQ_IN.learn_all && gc.learn_all_top_prio_en) ? QOS_TOP : FRM_REQ_IN.qos;
		next_rsp.fwd_mode  = FRM_REQ_IN.fwd_mode;
		if (!gc.forward_mode_translate_off
			&& (FRM_REQ_IN.fwd_mode == FWD_LOGICAL || FRM_REQ_IN.fwd_mode == FWD_MULTICAST)) begin
			next_rsp.fwd_mode = FWD_LOOKUP;
		end
		// only front ports follow the original tagging of a remote mirror copy
		next_rsp.mirror_tag = !pc.stack_header_insert_en && FRM_REQ_IN.fwd_mode == FWD_GLOBAL_MIRROR
			&& (pc.remote_mirror_tag_follow ? FRM_REQ_IN.was_tagged : 1'b1);
		next_rsp.misc_field_decode_sel = pc.misc_field_decode_sel;
		next_rsp.service_count_en = !(count_off && pc.stack_header_insert_en);
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			FRM_VALID_OUT <= 1'b0;
			FRM_RSP_OUT   <= '0;
		end else begin
			FRM_VALID_OUT <= FRM_VALID_IN;
			if (FRM_VALID_IN) begin
				FRM_RSP_OUT <= next_rsp;
			end
		end
	end

	// each pushed tag takes a fresh sequence number
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			seq_cnt    <= 16'h0000;
			refuse_cnt <= 16'h0000;
		end else if (FRM_VALID_IN) begin
			if (do_push) begin
				seq_cnt <= seq_cnt + 16'h0001;
			end
			if (next_rsp.push_refused) begin
				refuse_cnt <= refuse_cnt + 16'h0001;
			end
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	sequence s_req_pop;
		FRM_VALID_IN && aware && FRM_REQ_IN.redund_tag_pop_en && FRM_REQ_IN.ingress_redund_tag_seen;
	endsequence

	sequence s_rsp_push;
		FRM_VALID_OUT && FRM_RSP_OUT.redund_push;
	endsequence

	a_pop_front_clear: assert property (FRM_VALID_OUT && FRM_RSP_OUT.redund_pop |->
		$past(FRM_REQ_IN.vlan_pop_cnt) >= $past(FRM_REQ_IN.redund_pos) - 2'h1)
		else $error("redundancy tag popped with front tags left");
	a_pop_when_able: assert property (s_req_pop ##0 can_pop |=> FRM_VALID_OUT && FRM_RSP_OUT.redund_pop)
		else $error("allowed pop not done");
	a_one_tag_op: assert property (FRM_VALID_OUT |-> !(FRM_RSP_OUT.redund_keep && FRM_RSP_OUT.redund_pop))
		else $error("tag both kept and popped");
	a_push_needs_room: assert property (s_rsp_push |->
		!FRM_RSP_OUT.redund_keep && (FRM_RSP_OUT.redund_pop || !$past(FRM_REQ_IN.ingress_redund_tag_seen)))
		else $error("push over a kept tag");
	a_keep_alone: assert property (FRM_VALID_OUT && FRM_RSP_OUT.redund_keep |-> !FRM_RSP_OUT.redund_push)
		else $error("kept tag also pushed");
	a_push_slot_used: assert property (FRM_VALID_OUT && FRM_RSP_OUT.redund_push |->
		FRM_RSP_OUT.redund_out_pos == $past(FRM_REQ_IN.redund_tag_push_pos)
		&& FRM_RSP_OUT.redund_out_pos <= $past(FRM_REQ_IN.vlan_push_cnt))
		else $error("pushed tag in wrong slot");
	a_unaware_no_pop: assert property (FRM_VALID_IN && !aware |=> !FRM_RSP_OUT.redund_pop && !FRM_RSP_OUT.redund_push)
		else $error("tag touched while unaware");
	a_seq_advance: assert property (s_rsp_push |-> seq_cnt == FRM_RSP_OUT.frame_sequence_count + 16'h0001)
		else $error("sequence not advanced on push");
	a_replace_seq: assert property (FRM_VALID_OUT |->
		FRM_RSP_OUT.new_sequence == (FRM_RSP_OUT.redund_pop && FRM_RSP_OUT.redund_push))
		else $error("replace flag wrong");
	a_pad_length: assert property (FRM_VALID_OUT |->
		FRM_RSP_OUT.min_len == ($past(port_cfg[FRM_REQ_IN.port].stack_pad_en) ? MIN_LEN_STACK : MIN_LEN_PLAIN))
		else $error("wrong minimum length");
	a_unit_id: assert property (FRM_VALID_OUT |-> FRM_RSP_OUT.stack_unit_id == $past(local_unit_id))
		else $error("wrong local unit id");
	a_qos_raise: assert property (FRM_VALID_OUT && $past(FRM_REQ_IN.learn_all) |->
		FRM_RSP_OUT.stack_qos == ($past(grp_cfg[grp].learn_all_top_prio_en) ? QOS_TOP : $past(FRM_REQ_IN.qos)))
		else $error("learn-all priority wrong");
	a_count_gate: assert property (FRM_VALID_OUT && !FRM_RSP_OUT.service_count_en |->
		$past(count_off) && FRM_RSP_OUT.stack_header_insert_en)
		else $error("service counting wrongly off");
	a_mode_xlate: assert property (FRM_VALID_OUT |-> $past(grp_cfg[grp].forward_mode_translate_off)
		|| (FRM_RSP_OUT.fwd_mode != FWD_LOGICAL && FRM_RSP_OUT.fwd_mode != FWD_MULTICAST))
		else $error("logical mode not translated");
endmodule
`default_nettype wire

// [dv/ert_queue_model.sv]
// queue system side model: issues frame descriptors and collects decisions
`timescale 1ns/10ps
`default_nettype none
module ert_queue_model
	import ert_pkg::*;
(
	// clock
	input  wire logic        clk_in,
	// decision from rewriter
	input  wire ert_rsp_type rsp_in,
	input  wire logic        valid_in,
	// descriptor toward rewriter
	output var  ert_req_type req_out,
	output var  logic        valid_out
);
	initial begin
		req_out = '0;
		valid_out = 1'b0;
	end

	// one pulse per frame; descriptor is scrambled after the pulse so stale data cannot pass
	task automatic send(input ert_req_type r, output ert_rsp_type rsp, output logic ok);
		@(posedge clk_in);
		req_out <= r;
		valid_out <= 1'b1;
		@(posedge clk_in);
		valid_out <= 1'b0;
		req_out <= ~r;
		#1;
		ok = valid_in;
		rsp = rsp_in;
	endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the egress rewriter
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ert_pkg::*;
	logic        clk, rst;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	ert_req_type frm_req;
	ert_rsp_type rsp, frm_rsp;
	logic        frm_vin, frm_vout;
	int          error_cnt = 0;
	int          n_checks = 0;

	ert_rewriter u_dut (.MCLK_IN(clk), .SYS_RST_IN(rst),
		.AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
		.WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
		.BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
		.RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
		.FRM_REQ_IN(frm_req), .FRM_VALID_IN(frm_vin), .FRM_RSP_OUT(frm_rsp), .FRM_VALID_OUT(frm_vout));

	ert_queue_model u_src (.clk_in(clk), .rsp_in(frm_rsp), .valid_in(frm_vout),
		.req_out(frm_req), .valid_out(frm_vin));

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hang();
		error_cnt++;
		$display("unexpected at %0t: bus wait ran out", $time);
		summarize();
	endtask

	// write address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		bready <= 1'b0;
		if (i == 40) hang();
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		rready <= 1'b0;
		if (i == 40) hang();
		chk(rdata, ed);
		chk(rresp, er);
	endtask

	function automatic ert_req_type mk(input logic [1:0] cnt, pos, input logic seen,
		input logic [1:0] pcnt, qcnt, input logic pen, input logic [1:0] ppos);
		ert_req_type r;
		r = '0;
		r.tag_cnt = cnt;
		r.redund_pos = pos;
		r.ingress_redund_tag_seen = seen;
		r.vlan_pop_cnt = pcnt;
		r.vlan_push_cnt = qcnt;
		r.redund_tag_pop_en = pen;
		r.redund_tag_push_pos = ppos;
		return r;
	endfunction

	task automatic frame(input ert_req_type r);
		logic ok;
		u_src.send(r, rsp, ok);
		chk(ok, 1'b1);
	endtask

	task automatic t_reset();
		chk({frm_vout, awready, bvalid, rvalid}, 4'h0);
		rst <= 1'b0;
		rd(8'h04, 32'h0, RESP_OKAY);
		rd(8'h14, 32'h1F, RESP_OKAY);
		rd(8'h1C, 32'h0, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
		wr(8'h05, 32'hFFFF_FFFF, RESP_SLVERR);
		rd(8'h04, 32'h0, RESP_OKAY);
		$display("test reset done");
	endtask

	task automatic t_pop();
		wr(8'h00, 32'h1, RESP_OKAY);
		frame(mk(2'd2, 2'd2, 1'b1, 2'd1, 2'd0, 1'b1, 2'd0));
		chk({rsp.redund_pop, rsp.redund_keep, rsp.redund_push}, 3'b100);
		frame(mk(2'd2, 2'd2, 1'b1, 2'd0, 2'd1, 1'b1, 2'd1));
		chk({rsp.redund_pop, rsp.redund_keep, rsp.redund_push, rsp.redund_out_pos}, 5'b01011);
		chk(rsp.push_refused, 1'b1);
		frame(mk(2'd1, 2'd1, 1'b1, 2'd0, 2'd2, 1'b0, 2'd0));
		chk({rsp.redund_keep, rsp.redund_out_pos}, 3'b111);
		frame(mk(2'd0, 2'd2, 1'b1, 2'd0, 2'd0, 1'b0, 2'd0));
		chk(rsp.pos_invalid, 1'b1);
		frame(mk(2'd3, 2'd1, 1'b1, 2'd0, 2'd0, 1'b0, 2'd0));
		chk(rsp.pos_invalid, 1'b1);
		frame(mk(2'd2, 2'd3, 1'b1, 2'd0, 2'd0, 1'b0, 2'd0));
		chk({rsp.pos_invalid, rsp.redund_keep, rsp.redund_out_pos}, 4'b0111);
		$display("test pop done");
	endtask

	task automatic t_push();
		frame(mk(2'd1, 2'd0, 1'b0, 2'd0, 2'd2, 1'b0, 2'd2));
		chk({rsp.redund_push, rsp.push_refused, rsp.redund_out_pos}, 4'b1010);
		chk(rsp.frame_sequence_count, 16'h0);
		frame(mk(2'd1, 2'd1, 1'b1, 2'd0, 2'd1, 1'b1, 2'd1));
		chk({rsp.redund_pop, rsp.redund_push, rsp.new_sequence}, 3'b111);
		chk(rsp.frame_sequence_count, 16'h1);
		frame(mk(2'd0, 2'd0, 1'b0, 2'd0, 2'd2, 1'b0, 2'd3));
		chk({rsp.redund_push, rsp.push_refused}, 2'b01);
		frame(mk(2'd0, 2'd1, 1'b0, 2'd0, 2'd1, 1'b0, 2'd1));
		chk({rsp.redund_keep, rsp.redund_push, rsp.push_refused}, 3'b101);
		rd(8'h1C, 32'h0003_0002, RESP_OKAY);
		$display("test push done");
	endtask

	task automatic t_stack();
		ert_req_type r;
		wr(8'h00, 32'h2A3, RESP_OKAY);
		wr(8'h04, 32'h17, RESP_OKAY);
		wr(8'h18, 32'h105, RESP_OKAY);
		rd(8'h00, 32'h2A3, RESP_OKAY);
		r = mk(2'd0, 2'd0, 1'b0, 2'd0, 2'd0, 1'b0, 2'd0);
		r.learn_all = 1'b1;
		r.qos = 3'd3;
		r.fwd_mode = FWD_LOGICAL;
		frame(r);
		chk({rsp.stack_header_insert_en, rsp.min_len}, {1'b1, MIN_LEN_STACK});
		chk(rsp.stack_unit_id, 6'h2A);
		chk({rsp.stack_link_hop_limit, rsp.stack_qos}, {5'h05, QOS_TOP});
		chk(rsp.fwd_mode, FWD_LOOKUP);
		chk({rsp.misc_field_decode_sel, rsp.service_count_en}, 2'b10);
		r.port = 2'd1;
		r.fwd_mode = FWD_GLOBAL_MIRROR;
		frame(r);
		chk({rsp.stack_header_insert_en, rsp.min_len}, {1'b0, MIN_LEN_PLAIN});
		chk({rsp.stack_qos, rsp.mirror_tag, rsp.service_count_en}, 5'b01111);
		wr(8'h08, 32'h8, RESP_OKAY);
		frame(r);
		chk(rsp.mirror_tag, 1'b0);
		wr(8'h18, 32'h305, RESP_OKAY);
		r.port = 2'd0;
		r.fwd_mode = FWD_MULTICAST;
		frame(r);
		chk(rsp.fwd_mode, FWD_MULTICAST);
		$display("test stack done");
	endtask

	task automatic t_unaware();
		wr(8'h00, 32'h0, RESP_OKAY);
		frame(mk(2'd1, 2'd1, 1'b1, 2'd0, 2'd0, 1'b1, 2'd0));
		chk(rsp.redund_pop, 1'b0);
		frame(mk(2'd0, 2'd0, 1'b0, 2'd0, 2'd1, 1'b0, 2'd1));
		chk({rsp.redund_push, rsp.push_refused}, 2'b01);
		$display("test unaware done");
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		repeat (6) @(posedge clk);
		t_reset();
		t_pop();
		t_push();
		t_stack();
		t_unaware();
		summarize();
	end
endmodule
`default_nettype wire
